// [shared/uvf_pkg.sv]
package uvf_pkg;
	// Command codes of the two registers
	localparam logic [7:0] CMD_FAULT_RESP = 8'h45;
	localparam logic [7:0] CMD_TIME_UNIT = 8'hC8;
	// Field layout of the response byte
	localparam int RESP_MSB = 7;
	localparam int RESP_LSB = 6;
	localparam int RETRY_MSB = 5;
	localparam int RETRY_LSB = 3;
	localparam int DELAY_MSB = 2;
	localparam int DELAY_LSB = 0;
	// Response modes
	localparam logic [1:0] RESP_IGNORE = 2'h0;
	localparam logic [1:0] RESP_DELAY_RETRY = 2'h1;
	localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
	localparam logic [1:0] RESP_HOLD_OFF = 2'h3;
	// Retry settings with special meaning
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	// Reset values
	localparam logic [7:0] FAULT_RESP_RESET = 8'h80;
	localparam logic [15:0] TIME_UNIT_RESET = 16'h0001;
	// Timing: one base step of the time unit register
	localparam int CLK_PERIOD_NS = 50;
	localparam int BASE_STEP_NS = 1000;
	localparam int BASE_STEP_CYCLES = (BASE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Width of the delay timer: 2**7 units at most
	localparam int TIMER_W = 8;

	typedef enum logic [5:0] {
		UVF_RUN = 6'h01,
		UVF_DELAY = 6'h02,
		UVF_OFF_WAIT = 6'h04,
		UVF_RETRY = 6'h08,
		UVF_HOLD = 6'h10,
		UVF_LATCHED = 6'h20
	} uvf_state_e;
endpackage

// [hdl/uvf_tick_gen.sv]
`timescale 1ns/1ps
module uvf_tick_gen #(
	parameter int UNIT_W = 16,
	parameter int BASE_CYCLES = uvf_pkg::BASE_STEP_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic restart_i,
	input wire logic [UNIT_W-1:0] unit_i,
	output logic tick_o
);
	logic [15:0] pre_cnt;
	logic [UNIT_W-1:0] unit_cnt;
	logic base_pulse;
	logic [UNIT_W-1:0] unit_last;

	generate
		if (BASE_CYCLES < 1 || BASE_CYCLES > 65535 || UNIT_W < 1) begin : g_bad
			$error("uvf_tick_gen: unsupported parameters");
		end
	endgenerate

	assign base_pulse = (pre_cnt == 16'(BASE_CYCLES - 1));
	// A zero unit is served as one step, so the timer never stalls
	assign unit_last = (unit_i == '0) ? '0 : unit_i - UNIT_W'(1);

	always_ff @(posedge clk_i) begin
		if (rst_i || restart_i || base_pulse) begin
			pre_cnt <= 16'h0000;
		end else begin
			pre_cnt <= pre_cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || restart_i) begin
			unit_cnt <= '0;
		end else if (base_pulse) begin
			unit_cnt <= (unit_cnt >= unit_last) ? '0 : unit_cnt + UNIT_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || restart_i) begin
			tick_o <= 1'b0;
		end else begin
			tick_o <= base_pulse && (unit_cnt >= unit_last); // [RULE13]
		end
	end
endmodule // uvf_tick_gen

// [hdl/uvf_fault_resp.sv]
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Response byte is written and read at command code 45h.
// RULE2 - Mode 00: output keeps running, fault ignored.
// RULE3 - Mode 01: run for the delay, then retry handling if fault remains.
// RULE4 - Mode 10: disable output at once, then retry handling.
// RULE5 - Mode 11: output off only while fault present, then back on.
// RULE6 - Latched fault cleared by bit clear, clear-all, reset, off-on, bias loss; the code has no bias-loss input.
// RULE7 - Retry 000: no restart, output stays off until cleared.
// RULE8 - Retry 1..6: that many attempts, then off until cleared.
// RULE9 - Attempt starts spaced by two to the delay field value times time unit.
// RULE10 - Retry 111: retry forever until off, reset, or another shutdown.
// RULE11 - Delay field selects two to the field value time units.
// RULE12 - One delay field serves both run delay and retry spacing.
// RULE13 - Time unit length comes from the register at command C8h.
// RULE14 - Attempt counter and timer reset on clear or off command; a shutdown or last failure in the clear cycle latches instead.
module uvf_fault_resp #(
	parameter int UNIT_W = 16,
	parameter int BASE_CYCLES = uvf_pkg::BASE_STEP_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cmd_wr_i,
	input wire logic cmd_rd_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic [15:0] cmd_data_i,
	output logic [15:0] rd_data_o,
	output logic rd_valid_o,
	output logic rd_err_o,
	input wire logic fault_i,
	input wire logic on_cmd_i,
	input wire logic clear_bit_i,
	input wire logic clear_all_i,
	input wire logic ext_reset_i,
	input wire logic other_shutdown_i,
	output logic out_en_o,
	output logic latched_o,
	output logic [2:0] attempts_o,
	output logic [5:0] state_o
);
	logic [7:0] fault_resp;
	logic [UNIT_W-1:0] time_unit;
	uvf_pkg::uvf_state_e state;
	uvf_pkg::uvf_state_e next_state;
	logic [2:0] attempts;
	logic [uvf_pkg::TIMER_W-1:0] timer_cnt;
	logic [uvf_pkg::TIMER_W-1:0] timer_last;
	logic tick;
	logic t_done;
	logic timer_restart;
	logic clear_any;
	logic resp_wr;
	logic attempt_failed;
	logic [1:0] resp;
	logic [2:0] retry;
	logic [2:0] dly;

	generate
		if (UNIT_W < 1 || UNIT_W > 16) begin : g_bad
			$error("uvf_fault_resp: UNIT_W must be 1 to 16");
		end
	endgenerate

	function automatic logic [uvf_pkg::TIMER_W-1:0] units_last(input logic [2:0] f);
		logic [8:0] n;
		n = 9'h001 << f;
		return 8'(n - 9'h001); // [RULE11]
	endfunction

	assign resp = fault_resp[uvf_pkg::RESP_MSB:uvf_pkg::RESP_LSB];
	assign retry = fault_resp[uvf_pkg::RETRY_MSB:uvf_pkg::RETRY_LSB];
	assign dly = fault_resp[uvf_pkg::DELAY_MSB:uvf_pkg::DELAY_LSB];
	assign clear_any = clear_bit_i || clear_all_i || ext_reset_i; // [RULE6]
	assign resp_wr = cmd_wr_i && cmd_code_i == uvf_pkg::CMD_FAULT_RESP;
	assign timer_last = units_last(dly); // [RULE12]
	assign t_done = tick && (timer_cnt == timer_last);
	assign attempt_failed = (state == uvf_pkg::UVF_RETRY) && t_done && fault_i;

	// Register writes; unknown codes are ignored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_resp <= uvf_pkg::FAULT_RESP_RESET;
		end else if (resp_wr) begin
			fault_resp <= cmd_data_i[7:0]; // [RULE1]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			time_unit <= UNIT_W'(uvf_pkg::TIME_UNIT_RESET);
		end else if (cmd_wr_i && cmd_code_i == uvf_pkg::CMD_TIME_UNIT) begin
			time_unit <= cmd_data_i[UNIT_W-1:0]; // [RULE13]
		end
	end

	// Register reads answer one cycle later
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_data_o <= 16'h0000;
			rd_valid_o <= 1'b0;
			rd_err_o <= 1'b0;
		end else begin
			rd_valid_o <= cmd_rd_i;
			rd_err_o <= 1'b0;
			rd_data_o <= 16'h0000;
			if (cmd_rd_i) begin
				if (cmd_code_i == uvf_pkg::CMD_FAULT_RESP) begin
					rd_data_o <= {8'h00, fault_resp}; // [RULE1]
				end else if (cmd_code_i == uvf_pkg::CMD_TIME_UNIT) begin
					rd_data_o <= 16'(time_unit);
				end else begin
					rd_err_o <= 1'b1;
				end
			end
		end
	end

	// Restarting the unit divider too keeps every interval whole; a new delay field restarts it
	assign timer_restart = (next_state != state) || attempt_failed || !on_cmd_i || resp_wr; // [RULE14]

	uvf_tick_gen #(
		.UNIT_W(UNIT_W),
		.BASE_CYCLES(BASE_CYCLES)
	) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.restart_i(timer_restart),
		.unit_i(time_unit),
		.tick_o(tick)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i || timer_restart) begin
			timer_cnt <= '0; // [RULE14]
		end else if (tick) begin
			timer_cnt <= t_done ? '0 : timer_cnt + 8'h01; // [RULE9]
		end
	end

	always_comb begin
		next_state = state;
		if (!on_cmd_i) begin
			next_state = uvf_pkg::UVF_RUN; // [RULE6]
		end else begin
			unique case (state)
				uvf_pkg::UVF_RUN: begin
					if (fault_i) begin
						unique case (resp)
							uvf_pkg::RESP_IGNORE: next_state = uvf_pkg::UVF_RUN; // [RULE2]
							uvf_pkg::RESP_DELAY_RETRY: next_state = uvf_pkg::UVF_DELAY; // [RULE3]
							uvf_pkg::RESP_DISABLE_RETRY: begin
								next_state = (retry == uvf_pkg::RETRY_NONE) ?
									uvf_pkg::UVF_LATCHED : uvf_pkg::UVF_OFF_WAIT; // [RULE4] [RULE7]
							end
							uvf_pkg::RESP_HOLD_OFF: next_state = uvf_pkg::UVF_HOLD; // [RULE5]
						endcase
					end
				end
				uvf_pkg::UVF_DELAY: begin
					if (!fault_i) begin
						next_state = uvf_pkg::UVF_RUN;
					end else if (t_done) begin
						next_state = (retry == uvf_pkg::RETRY_NONE) ?
							uvf_pkg::UVF_LATCHED : uvf_pkg::UVF_OFF_WAIT; // [RULE3] [RULE7]
					end
				end
				uvf_pkg::UVF_OFF_WAIT: begin
					if (other_shutdown_i) begin
						next_state = uvf_pkg::UVF_LATCHED; // [RULE10]
					end else if (clear_any) begin
						next_state = uvf_pkg::UVF_RUN; // [RULE6]
					end else if (t_done) begin
						next_state = uvf_pkg::UVF_RETRY; // [RULE9]
					end
				end
				uvf_pkg::UVF_RETRY: begin
					// A shutdown or last failure in the clear cycle wins over the clear
					if (other_shutdown_i) begin
						next_state = uvf_pkg::UVF_LATCHED; // [RULE10]
					end else if (t_done && fault_i && retry != uvf_pkg::RETRY_FOREVER && attempts + 3'h1 >= retry) begin
						next_state = uvf_pkg::UVF_LATCHED; // [RULE8]
					end else if (clear_any || (t_done && !fault_i)) begin
						next_state = uvf_pkg::UVF_RUN; // [RULE6]
					end
				end
				uvf_pkg::UVF_HOLD: begin
					if (!fault_i) begin
						next_state = uvf_pkg::UVF_RUN; // [RULE5]
					end
				end
				uvf_pkg::UVF_LATCHED: begin
					if (clear_any) begin
						next_state = uvf_pkg::UVF_RUN; // [RULE6]
					end
				end
				default: next_state = uvf_pkg::UVF_LATCHED;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= uvf_pkg::UVF_RUN;
		end else begin
			state <= next_state;
		end
	end

	// Counts failed attempts; kept while latched for visibility
	always_ff @(posedge clk_i) begin
		if (rst_i || next_state == uvf_pkg::UVF_RUN) begin
			attempts <= 3'h0; // [RULE14]
		end else if (attempt_failed && attempts != uvf_pkg::RETRY_FOREVER) begin
			attempts <= attempts + 3'h1; // [RULE8] [RULE10]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_en_o <= 1'b0;
			latched_o <= 1'b0;
		end else begin
			out_en_o <= on_cmd_i && (next_state == uvf_pkg::UVF_RUN || next_state == uvf_pkg::UVF_DELAY ||
				next_state == uvf_pkg::UVF_RETRY); // [RULE2] [RULE3] [RULE4]
			latched_o <= (next_state == uvf_pkg::UVF_LATCHED);
		end
	end

	assign attempts_o = attempts;
	assign state_o = state;

	sequence s_fault_in_run;
		state == uvf_pkg::UVF_RUN && on_cmd_i && fault_i;
	endsequence

	sequence s_disable_fault;
		s_fault_in_run ##0 (resp == uvf_pkg::RESP_DISABLE_RETRY);
	endsequence

	property p_ignore;
		@(posedge clk_i) disable iff (rst_i)
		s_fault_in_run ##0 (resp == uvf_pkg::RESP_IGNORE) |=> out_en_o && state == uvf_pkg::UVF_RUN;
	endproperty
	a_ignore: assert property (p_ignore) else $error("ignore mode interrupted output"); // [RULE2]

	property p_delay_on;
		@(posedge clk_i) disable iff (rst_i)
		s_fault_in_run ##0 (resp == uvf_pkg::RESP_DELAY_RETRY) |=> state == uvf_pkg::UVF_DELAY && out_en_o;
	endproperty
	a_delay_on: assert property (p_delay_on) else $error("delay mode did not keep output on"); // [RULE3]

	property p_disable_now;
		@(posedge clk_i) disable iff (rst_i)
		s_disable_fault |=> !out_en_o;
	endproperty
	a_disable_now: assert property (p_disable_now) else $error("output not disabled on fault"); // [RULE4]

	property p_no_retry;
		@(posedge clk_i) disable iff (rst_i)
		s_disable_fault ##0 (retry == uvf_pkg::RETRY_NONE) |=> latched_o ##1 (latched_o || !$past(on_cmd_i) ||
			$past(clear_any));
	endproperty
	a_no_retry: assert property (p_no_retry) else $error("no-retry setting did not latch"); // [RULE7]

	property p_hold;
		@(posedge clk_i) disable iff (rst_i)
		state == uvf_pkg::UVF_HOLD && on_cmd_i && !fault_i |=> state == uvf_pkg::UVF_RUN ##1
			(out_en_o || !$past(on_cmd_i) || $past(fault_i));
	endproperty
	a_hold: assert property (p_hold) else $error("hold mode did not resume"); // [RULE5]

	property p_clear;
		@(posedge clk_i) disable iff (rst_i)
		state == uvf_pkg::UVF_LATCHED && clear_any |=> state == uvf_pkg::UVF_RUN && attempts == 3'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not release latched fault"); // [RULE6]

	property p_off_resets;
		@(posedge clk_i) disable iff (rst_i)
		!on_cmd_i |=> attempts == 3'h0 && timer_cnt == '0 && !out_en_o;
	endproperty
	a_off_resets: assert property (p_off_resets) else $error("off command did not reset retry state"); // [RULE14]

	property p_limit;
		@(posedge clk_i) disable iff (rst_i)
		state == uvf_pkg::UVF_RETRY && retry != uvf_pkg::RETRY_FOREVER |-> attempts < retry;
	endproperty
	a_limit: assert property (p_limit) else $error("retry count exceeded"); // [RULE8]

	property p_forever;
		@(posedge clk_i) disable iff (rst_i)
		attempt_failed && retry == uvf_pkg::RETRY_FOREVER && on_cmd_i && !clear_any && !other_shutdown_i
			|=> state == uvf_pkg::UVF_RETRY;
	endproperty
	a_forever: assert property (p_forever) else $error("continuous retry stopped"); // [RULE10]

	property p_timer_bound;
		@(posedge clk_i) disable iff (rst_i)
		$stable(dly) |-> timer_cnt <= timer_last;
	endproperty
	a_timer_bound: assert property (p_timer_bound) else $error("delay timer passed its limit"); // [RULE11]
endmodule // uvf_fault_resp

// [sim/uvf_host_model.sv]
`timescale 1ns/1ps
module uvf_host_model (
	input wire logic clk_i,
	input wire logic [15:0] rd_data_i,
	input wire logic rd_valid_i,
	input wire logic rd_err_i,
	output logic cmd_wr_o,
	output logic cmd_rd_o,
	output logic [7:0] cmd_code_o,
	output logic [15:0] cmd_data_o,
	output logic clear_bit_o,
	output logic clear_all_o
);
	initial begin
		{cmd_wr_o, cmd_rd_o, clear_bit_o, clear_all_o} = 4'h0;
		cmd_code_o = 8'h00;
		cmd_data_o = 16'h0000;
	end
	task automatic wr(input logic [7:0] code, input logic [15:0] data);
		@(negedge clk_i);
		cmd_code_o = code;
		cmd_data_o = data;
		cmd_wr_o = 1'b1;
		@(negedge clk_i);
		cmd_wr_o = 1'b0;
	endtask
	// Bounded wait: a missing answer leaves the data unknown, so the compare fails
	task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic err);
		data = 16'hXXXX;
		err = 1'bX;
		@(negedge clk_i);
		cmd_code_o = code;
		cmd_rd_o = 1'b1;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk_i);
			cmd_rd_o = 1'b0;
			if (rd_valid_i === 1'b1) begin
				data = rd_data_i;
				err = rd_err_i;
				i = 4;
			end
		end
	endtask
	task automatic clr(input logic all);
		@(negedge clk_i);
		if (all) clear_all_o = 1'b1;
		else clear_bit_o = 1'b1;
		@(negedge clk_i);
		{clear_bit_o, clear_all_o} = 2'h0;
	endtask
endmodule // uvf_host_model

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	logic clk_i = 1'b0, rst_i = 1'b1, fault_i = 1'b0, on_cmd_i = 1'b1, ext_reset_i = 1'b0, other_shutdown_i = 1'b0;
	logic cmd_wr_i, cmd_rd_i, clear_bit_i, clear_all_i, rd_valid_o, rd_err_o, out_en_o, latched_o;
	logic [7:0] cmd_code_i;
	logic [15:0] cmd_data_i, rd_data_o, d;
	logic [2:0] attempts_o;
	logic [5:0] state_o;
	logic e;
	int err_count = 0, n_compared = 0;
	always #25 clk_i = ~clk_i;
	uvf_fault_resp #(.BASE_CYCLES(1)) u_uvf_fault_resp (.clk_i(clk_i), .rst_i(rst_i), .cmd_wr_i(cmd_wr_i),
		.cmd_rd_i(cmd_rd_i), .cmd_code_i(cmd_code_i), .cmd_data_i(cmd_data_i), .rd_data_o(rd_data_o),
		.rd_valid_o(rd_valid_o), .rd_err_o(rd_err_o), .fault_i(fault_i), .on_cmd_i(on_cmd_i),
		.clear_bit_i(clear_bit_i), .clear_all_i(clear_all_i), .ext_reset_i(ext_reset_i),
		.other_shutdown_i(other_shutdown_i), .out_en_o(out_en_o), .latched_o(latched_o),
		.attempts_o(attempts_o), .state_o(state_o));
	uvf_host_model u_uvf_host_model (.clk_i(clk_i), .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o),
		.rd_err_i(rd_err_o), .cmd_wr_o(cmd_wr_i), .cmd_rd_o(cmd_rd_i), .cmd_code_o(cmd_code_i),
		.cmd_data_o(cmd_data_i), .clear_bit_o(clear_bit_i), .clear_all_o(clear_all_i));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic t_regs();
		u_uvf_host_model.rd(8'h45, d, e);
		chk(d, 16'h0080, "resp reset");
		chk(16'(e), 16'h0000, "known code");
		u_uvf_host_model.rd(8'hC8, d, e);
		chk(d, 16'h0001, "unit reset");
		u_uvf_host_model.wr(8'h45, 16'hA5C3);
		u_uvf_host_model.rd(8'h45, d, e);
		chk(d, 16'h00C3, "resp write");
		u_uvf_host_model.rd(8'h46, d, e);
		chk(16'(e), 16'h0001, "unknown code");
		chk(d, 16'h0000, "unknown data");
		// Unit of 3 steps, so interval checks test the multiply
		u_uvf_host_model.wr(8'hC8, 16'h0003);
		u_uvf_host_model.rd(8'hC8, d, e);
		chk(d, 16'h0003, "unit write");
		$display("test regs done");
	endtask
	task automatic t_mode(input logic [7:0] resp, input logic [5:0] st, input logic en);
		u_uvf_host_model.wr(8'h45, {8'h00, resp});
		fault_i = 1'b1;
		cyc(30);
		chk(16'({state_o, out_en_o}), 16'({st, en}), "fault held");
		fault_i = 1'b0;
		cyc(3);
		chk(16'({state_o, out_en_o}), 16'h0003, "fault gone");
		$display("test mode %h done", resp);
	endtask
	task automatic t_delay(input int kind);
		u_uvf_host_model.wr(8'h45, 16'h0042);
		if (kind == 0) begin
			fault_i = 1'b1;
			cyc(5);
			fault_i = 1'b0;
			cyc(2);
			chk(16'({state_o, out_en_o}), 16'h0003, "fault gone early");
		end
		fault_i = 1'b1;
		cyc(10);
		chk(16'({state_o, out_en_o}), 16'h0005, "delay run");
		cyc(16);
		chk(16'({latched_o, out_en_o}), 16'h0002, "latched");
		fault_i = 1'b0;
		cyc(4);
		chk(16'(out_en_o), 16'h0000, "stays off");
		if (kind < 2) u_uvf_host_model.clr(kind[0]);
		else if (kind == 2) ext_reset_i = 1'b1;
		else if (kind == 3) on_cmd_i = 1'b0;
		else rst_i = 1'b1;
		cyc(1);
		{ext_reset_i, on_cmd_i} = 2'h1;
		rst_i = 1'b0;
		cyc(3);
		chk(16'({latched_o, out_en_o, attempts_o}), 16'h0008, "cleared");
		if (kind == 4) begin
			u_uvf_host_model.rd(8'h45, d, e);
			chk(d, 16'h0080, "resp after reset");
		end
		$display("test delay clear %0d done", kind);
	endtask
	task automatic t_retry(input logic [2:0] n);
		int last;
		int ups;
		logic po;
		logic [2:0] pa;
		u_uvf_host_model.wr(8'h45, {8'h00, 2'h2, n, 3'h2});
		fault_i = 1'b1;
		cyc(2);
		chk(16'({state_o, out_en_o}), (n == uvf_pkg::RETRY_NONE) ? 16'h0040 : 16'h0008, "disabled");
		pa = 3'h0;
		last = -1;
		ups = 0;
		po = 1'b0;
		// Interval: 2**2 units of 3 steps of 1 cycle
		for (int c = 0; c < 400 && latched_o !== 1'b1; c++) begin
			@(negedge clk_i);
			if (out_en_o === 1'b1 && po !== 1'b1) ups++;
			po = out_en_o;
			if (attempts_o !== pa) begin
				if (last >= 0) chk(16'(c - last inside {[12:13]}), 16'h0001, "spacing");
				last = c;
				pa = attempts_o;
			end
		end
		chk(16'({latched_o, out_en_o, attempts_o}), 16'({2'h2, n}), "exhausted");
		chk(16'(ups > 0), 16'(n != 3'h0), "restarted");
		fault_i = 1'b0;
		u_uvf_host_model.clr(1'b1);
		cyc(3);
		chk(16'({latched_o, out_en_o, attempts_o}), 16'h0008, "clear retry");
		$display("test retry %0d done", n);
	endtask
	task automatic t_forever();
		u_uvf_host_model.wr(8'h45, 16'h00BA);
		fault_i = 1'b1;
		cyc(150);
		chk(16'({latched_o, attempts_o}), 16'h0007, "unlimited");
		other_shutdown_i = 1'b1;
		cyc(1);
		other_shutdown_i = 1'b0;
		cyc(2);
		chk(16'({latched_o, out_en_o}), 16'h0002, "other stop");
		fault_i = 1'b0;
		on_cmd_i = 1'b0;
		cyc(2);
		chk(16'({latched_o, out_en_o, attempts_o}), 16'h0000, "off cmd");
		on_cmd_i = 1'b1;
		cyc(2);
		chk(16'(out_en_o), 16'h0001, "on again");
		$display("test forever done");
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		end_of_test();
	end
	initial begin
		cyc(5);
		chk(16'({out_en_o, latched_o, state_o, rd_valid_o}), 16'h0002, "in reset");
		cyc(1);
		rst_i = 1'b0;
		cyc(1);
		chk(16'({out_en_o, latched_o, attempts_o}), 16'h0010, "after reset");
		cyc(1);
		t_regs();
		t_mode(8'h02, 6'h01, 1'b1);
		t_mode(8'hC2, 6'h10, 1'b0);
		for (int k = 0; k < 5; k++) t_delay(k);
		// The mid-run reset put the time unit back to one step
		u_uvf_host_model.wr(8'hC8, 16'h0003);
		t_retry(3'h0);
		t_retry(3'h1);
		t_retry(3'h6);
		t_forever();
		end_of_test();
	end
endmodule // tb_top
